// ### design/adc_control.sv
// converter control byte decode, power modes, result fifo and byte readout
//
// Contract
// - control byte: power, acquire, single, unipolar, address
// - single-ended: addressed input positive, shared negative
// - differential: pair by upper bits, bit0 picks polarity
// - power-up: external clock, done output high
// - upper-byte select chooses low byte or nibble
// - upper read: top nibble zero or sign
// - power codes; power-down keeps clock mode
// - host port works in standby and shutdown
// - write edge wakes from standby
// - shutdown only after running conversion completes
// - write edge leaves shutdown
// - unipolar result is straight binary
// - bipolar result is two's complement
`default_nettype none

// ------------------------------------------------------------
// result fifo
// ------------------------------------------------------------
module result_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire  logic             sys_clk,
   input  wire  logic             nrst,
   // filling side
   input  wire  logic             in_valid,
   output logic                   in_ready,
   input  wire  logic [WIDTH-1:0] in_data,
   // draining side
   output logic                   out_valid,
   input  wire  logic             out_ready,
   output logic [WIDTH-1:0]       out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];   // storage, flip-flops
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [AW-1:0]    wr_ptr_q, wr_ptr_d; // next free slot
   logic [AW-1:0]    rd_ptr_q, rd_ptr_d; // oldest entry
   logic [AW:0]      cnt_q, cnt_d;       // occupancy
   logic             rdy_q, rdy_d;       // registered not-full
   logic             val_q, val_d;       // registered not-empty
   logic             push, pop;

   assign in_ready  = rdy_q;
   assign out_valid = val_q;
   assign out_data  = mem_q[rd_ptr_q];

   // next pointers and flags; flags registered so in_ready and out_valid come from flops
   always_comb begin
      push     = in_valid && rdy_q;
      pop      = out_ready && val_q;
      mem_d    = mem_q;
      wr_ptr_d = wr_ptr_q;
      rd_ptr_d = rd_ptr_q;
      cnt_d    = cnt_q;
      if (push) begin
         mem_d[wr_ptr_q] = in_data;
         wr_ptr_d        = (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
         rd_ptr_d = (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
      rdy_d = (cnt_d != FULL_CNT);
      val_d = (cnt_d != '0);
   end

   // register only
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q    <= '0;
         rdy_q    <= 1'b1;
         val_q    <= 1'b0;
      end else begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         cnt_q    <= cnt_d;
         rdy_q    <= rdy_d;
         val_q    <= val_d;
      end
      mem_q <= mem_d;  // data needs no reset, guarded by val_q
   end
endmodule : result_fifo

// ------------------------------------------------------------
// converter control top
// ------------------------------------------------------------
module adc_control
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input  wire  logic              sys_clk,
   input  wire  logic              nrst,
   // host parallel port
   input  wire  logic              cs_n,
   input  wire  logic              wr_n,
   input  wire  logic              rd_n,
   input  wire  logic              upper_byte_sel,
   input  wire  logic [CTRL_W-1:0] data_in,
   output logic [CTRL_W-1:0]       data_out,
   output logic                    data_oe_n,
   output logic                    conv_done_n,
   // successive-approximation core
   output logic                    conv_start,
   input  wire  logic              sar_valid,
   output logic                    sar_ready,
   input  wire  logic [RES_W-1:0]  sar_result,
   // analog control
   output logic [CH_N-1:0]         pos_sel,
   output logic [CH_N-1:0]         neg_sel,
   output logic                    shared_negative_input,
   output logic                    acquire_external_sel,
   output logic                    unipolar_sel,
   output logic                    clock_internal,
   output logic                    core_powered,
   output logic                    quiescent_on
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // one-hot input select from a 3-bit index
   function automatic logic [CH_N-1:0] onehot(input logic [ADDR_MSB:0] idx);
      onehot = CH_N'(1) << idx;
   endfunction : onehot

   // core gives offset binary; bipolar flips the sign bit to two's complement
   function automatic logic [RES_W-1:0] code(input logic [RES_W-1:0] raw,
                                             input logic uni);
      code = uni ? raw : {~raw[RES_MSB], raw[RES_MSB-1:0]};
   endfunction : code

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [CTRL_W-1:0] ctrl_q, ctrl_d;       // last control byte
   logic              wr_n_q, rd_n_q;        // previous strobe levels
   logic              clk_int_q, clk_int_d;  // clock mode, kept over power-down
   logic              busy_q, busy_d;        // conversion in flight
   logic              start_q, start_d;      // start pulse to core
   power_state_type   pwr_q, pwr_d;          // power state
   logic [CH_N-1:0]   pos_q, pos_d;          // positive input select
   logic [CH_N-1:0]   neg_q, neg_d;          // negative input select
   logic              com_q, com_d;          // shared negative selected
   logic [CTRL_W-1:0] dout_q, dout_d;        // bus byte
   logic              oe_n_q, oe_n_d;        // bus drive, low = driving
   logic              done_n_q, done_n_d;    // result waiting, active low
   logic              awake_q, awake_d;      // core powered, kept as a flop
   logic              bias_on_q, bias_on_d;  // quiescent functions on
   logic              wr_rise, rd_rise, rd_act, pop, conv_end;
   logic [1:0]        pm;
   logic [FIFO_W-1:0] head;
   logic              head_valid;
   logic [RES_W-1:0]  hres;

   // ------------------------------------------------------------
   // result buffer; full fifo stalls the core via sar_ready
   // ------------------------------------------------------------
   result_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_D)
   ) result_fifo_i (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .in_valid  (sar_valid && busy_q),
      .in_ready  (sar_ready),
      .in_data   ({ctrl_q[UNI_BIT], code(sar_result, ctrl_q[UNI_BIT])}),
      .out_valid (head_valid),
      .out_ready (pop),
      .out_data  (head)
   );

   assign hres = head[RES_W-1:0];

   // ------------------------------------------------------------
   // outputs straight from flops
   // ------------------------------------------------------------
   assign data_out              = dout_q;
   assign data_oe_n             = oe_n_q;
   assign conv_done_n           = done_n_q;
   assign conv_start            = start_q;
   assign pos_sel               = pos_q;
   assign neg_sel               = neg_q;
   assign shared_negative_input = com_q;
   assign acquire_external_sel  = ctrl_q[ACQ_BIT];
   assign unipolar_sel          = ctrl_q[UNI_BIT];
   assign clock_internal        = clk_int_q;
   assign core_powered          = awake_q;
   assign quiescent_on          = bias_on_q;

   // ------------------------------------------------------------
   // control, power and readout next state
   // ------------------------------------------------------------
   always_comb begin
      // strobe edges; port decoding ignores power state
      wr_rise  = !cs_n && !wr_n_q && wr_n;
      rd_rise  = !cs_n && !rd_n_q && rd_n;
      rd_act   = !cs_n && !rd_n;
      // upper byte read closes a result, so it retires the head
      pop      = rd_rise && upper_byte_sel && head_valid;
      conv_end = busy_q && sar_valid && sar_ready;
      ctrl_d    = ctrl_q;
      clk_int_d = clk_int_q;
      busy_d    = busy_q;
      start_d   = 1'b0;
      pwr_d     = pwr_q;
      pos_d     = pos_q;
      neg_d     = neg_q;
      com_d     = com_q;
      pm        = {ctrl_q[PM_HI_BIT], ctrl_q[PM_LO_BIT]};
      // finished conversion: now apply a pending power-down code
      if (conv_end) begin
         busy_d = 1'b0;
         unique case (pm)
            PM_SHUTDOWN: pwr_d = pwr_shutdown;
            PM_STANDBY:  pwr_d = pwr_standby;
            PM_INT_CLK,
            PM_EXT_CLK:  pwr_d = pwr_normal;
         endcase
      end
      // write edge: latch byte, wake, start a conversion
      if (wr_rise) begin
         ctrl_d = data_in;
         pm     = {data_in[PM_HI_BIT], data_in[PM_LO_BIT]};
         // power-down codes leave clock mode as it was
         if (pm == PM_INT_CLK) begin
            clk_int_d = 1'b1;
         end else if (pm == PM_EXT_CLK) begin
            clk_int_d = 1'b0;
         end
         pwr_d = pwr_normal;
         // a write during a conversion only reloads the fields
         if (!busy_d) begin
            busy_d  = 1'b1;
            start_d = 1'b1;
         end
         if (data_in[SGL_BIT]) begin
            // addressed input against the shared negative
            pos_d = onehot(data_in[ADDR_MSB:ADDR_LSB]);
            neg_d = '0;
            com_d = 1'b1;
         end else begin
            // pair from upper bits, bit 0 swaps polarity
            pos_d = onehot({data_in[ADDR_MSB:PAIR_LSB], data_in[ADDR_LSB]});
            neg_d = onehot({data_in[ADDR_MSB:PAIR_LSB], ~data_in[ADDR_LSB]});
            com_d = 1'b0;
         end
      end
      // bus byte: low byte, or nibble with zero or sign fill
      dout_d = dout_q;
      if (rd_act) begin
         if (!upper_byte_sel) begin
            dout_d = hres[BYTE_MSB:0];
         end else if (head[RES_W]) begin
            dout_d = {NIB_ZERO, hres[RES_MSB:RES_MSB-NIB_MSB]};
         end else begin
            dout_d = {{NIB_W{hres[RES_MSB]}}, hres[RES_MSB:RES_MSB-NIB_MSB]};
         end
      end
      oe_n_d   = !rd_act;
      // done flag low while a result waits; each pop lifts it for one cycle, the pop of the last one releases it
      done_n_d = !(head_valid && !pop);
      // power flags follow the next power state so the pins leave a flop
      awake_d   = (pwr_d == pwr_normal);
      bias_on_d = (pwr_d != pwr_shutdown);
   end

   // ------------------------------------------------------------
   // register only; reset brings external clock and done high
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ctrl_q    <= CTRL_RESET;
         wr_n_q    <= 1'b1;
         rd_n_q    <= 1'b1;
         clk_int_q <= 1'b0;
         busy_q    <= 1'b0;
         start_q   <= 1'b0;
         pwr_q     <= pwr_normal;
         pos_q     <= onehot(CTRL_RESET[ADDR_MSB:ADDR_LSB]);
         neg_q     <= onehot(CTRL_RESET[ADDR_MSB:ADDR_LSB] | 3'h1);
         com_q     <= 1'b0;
         dout_q    <= '0;
         oe_n_q    <= 1'b1;
         done_n_q  <= 1'b1;
         awake_q   <= 1'b1;
         bias_on_q <= 1'b1;
      end else begin
         ctrl_q    <= ctrl_d;
         wr_n_q    <= wr_n;
         rd_n_q    <= rd_n;
         clk_int_q <= clk_int_d;
         busy_q    <= busy_d;
         start_q   <= start_d;
         pwr_q     <= pwr_d;
         pos_q     <= pos_d;
         neg_q     <= neg_d;
         com_q     <= com_d;
         dout_q    <= dout_d;
         oe_n_q    <= oe_n_d;
         done_n_q  <= done_n_d;
         awake_q   <= awake_d;
         bias_on_q <= bias_on_d;
      end
   end
endmodule : adc_control
`default_nettype wire

// ### design/adc_ctrl_pkg.sv
// constants, field layout and state types shared by the converter control logic
`default_nettype none
package adc_ctrl_pkg;
   // ------------------------------------------------------------
   // data widths
   // ------------------------------------------------------------
   localparam int CTRL_W    = 8;   // control byte width
   localparam int RES_W     = 12;  // conversion result width
   localparam int RES_MSB   = 11;  // sign / most significant result bit
   localparam int BYTE_MSB  = 7;   // top bit of a bus byte
   localparam int NIB_MSB   = 3;   // top bit of the upper result nibble
   localparam int NIB_W     = 4;   // width of a nibble
   localparam int CH_N      = 8;   // analog input count
   localparam int FIFO_W    = 13;  // result plus its coding flag
   localparam int FIFO_D    = 16;  // stored results
   // ------------------------------------------------------------
   // control byte fields
   // ------------------------------------------------------------
   localparam int PM_HI_BIT  = 7;  // power_mode_hi
   localparam int PM_LO_BIT  = 6;  // power_mode_lo
   localparam int ACQ_BIT    = 5;  // acquire_external_sel
   localparam int SGL_BIT    = 4;  // single_ended_sel
   localparam int UNI_BIT    = 3;  // unipolar_sel
   localparam int ADDR_MSB   = 2;  // channel_addr_2
   localparam int ADDR_LSB   = 0;  // channel_addr_0
   localparam int PAIR_LSB   = 1;  // channel_addr_1, lowest pair bit
   // ------------------------------------------------------------
   // power mode codes and reset values
   // ------------------------------------------------------------
   localparam logic [1:0] PM_SHUTDOWN = 2'h0;  // full shutdown
   localparam logic [1:0] PM_STANDBY  = 2'h1;  // standby
   localparam logic [1:0] PM_INT_CLK  = 2'h2;  // normal, internal clock
   localparam logic [1:0] PM_EXT_CLK  = 2'h3;  // normal, external clock
   localparam logic [7:0] CTRL_RESET  = 8'hc0; // normal, external clock, ch0
   localparam logic [3:0] NIB_ZERO    = 4'h0;  // upper fill in unipolar
   typedef enum logic [1:0] {pwr_normal, pwr_standby, pwr_shutdown} power_state_type;
endpackage : adc_ctrl_pkg
`default_nettype wire

// ### sim/adc_control_monitor.sv
// port checker of the converter control block
`default_nettype none
module adc_control_monitor (
   // clock, reset, host port
   input wire logic       sys_clk,
   input wire logic       nrst,
   input wire logic       cs_n,
   input wire logic       wr_n,
   input wire logic       rd_n,
   input wire logic       upper_byte_sel,
   input wire logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic       data_oe_n,
   input wire logic       conv_done_n,
   // analog and power control
   input wire logic [7:0] pos_sel,
   input wire logic [7:0] neg_sel,
   input wire logic       shared_negative_input,
   input wire logic       acquire_external_sel,
   input wire logic       unipolar_sel,
   input wire logic       clock_internal,
   input wire logic       core_powered
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr_q;  // strobe a cycle back, high in reset so an idle high strobe gives no edge
   logic take;  // control byte taken at this edge
   always_ff @(posedge sys_clk) wr_q <= nrst ? wr_n : 1'b1;
   assign take = !cs_n && wr_n && !wr_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   AST_RESET: assert property ($rose(nrst) |-> conv_done_n && !clock_internal && data_oe_n)
      else $error("reset state wrong");
   AST_SINGLE: assert property (take && data_in[4] |=> pos_sel == 8'h01 << $past(data_in[2:0])
      && neg_sel == 8'h00 && shared_negative_input) else $error("single-ended route wrong");
   AST_PAIR: assert property (take && !data_in[4] |=> pos_sel == 8'h01 << $past(data_in[2:0])
      && neg_sel == 8'h01 << ($past(data_in[2:0]) ^ 3'h1) && !shared_negative_input)
      else $error("pair route wrong");
   AST_FIELDS: assert property (take |=> acquire_external_sel == $past(data_in[5])
      && unipolar_sel == $past(data_in[3])) else $error("field decode wrong");
   AST_CLOCK: assert property (take |=> clock_internal ==
      ($past(data_in[7]) ? !$past(data_in[6]) : $past(clock_internal)))
      else $error("clock mode wrong");
   AST_HOLD: assert property (!take |=> $stable(pos_sel) && $stable(neg_sel)
      && $stable(unipolar_sel) && $stable(clock_internal)) else $error("fields moved");
   AST_WAKE: assert property (take |=> core_powered) else $error("no wake on write");
   AST_DRIVE: assert property (!cs_n && !rd_n |=> !data_oe_n) else $error("bus not driven");
   AST_FLOAT: assert property (cs_n |=> data_oe_n) else $error("bus driven unselected");
   AST_UPPER: assert property (!cs_n && !rd_n && upper_byte_sel |=>
      data_out[7:4] == (unipolar_sel ? 4'h0 : {4{data_out[3]}})) else $error("upper fill wrong");
   // main scenarios
   cover property (take && data_in[4]);
   cover property (take && !data_in[7]);
   cover property (!cs_n && !rd_n && upper_byte_sel && !unipolar_sel);
endmodule : adc_control_monitor
bind adc_control adc_control_monitor adc_control_monitor_i (.sys_clk(sys_clk), .nrst(nrst),
   .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .upper_byte_sel(upper_byte_sel), .data_in(data_in),
   .data_out(data_out), .data_oe_n(data_oe_n), .conv_done_n(conv_done_n), .pos_sel(pos_sel),
   .neg_sel(neg_sel), .shared_negative_input(shared_negative_input),
   .acquire_external_sel(acquire_external_sel), .unipolar_sel(unipolar_sel),
   .clock_internal(clock_internal), .core_powered(core_powered));
`default_nettype wire

// ### sim/sar_core_model.sv
// behavioural conversion core: answers each start after a set delay
`default_nettype none
module sar_core_model (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // start and result handshake
   input  wire logic        conv_start,
   input  wire logic        sar_ready,
   output logic             sar_valid,
   output logic [11:0]      sar_result,
   // bench controls: next code and answer delay
   input  wire logic [11:0] code,
   input  wire logic [3:0]  lat
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        busy_q;  // conversion running
   logic [3:0]  cnt_q;   // cycles left
   logic [11:0] held_q;  // code caught at start
   // result held until taken; inverted afterwards so a stale read shows
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         busy_q     <= 1'b0;
         sar_valid  <= 1'b0;
         sar_result <= 12'h000;
      end else if (sar_valid) begin
         if (sar_ready) begin  // taken by the fifo
            sar_valid  <= 1'b0;
            sar_result <= ~sar_result;
         end
      end else if (busy_q) begin
         if (cnt_q == 4'h0) begin
            sar_valid  <= 1'b1;
            sar_result <= held_q;
            busy_q     <= 1'b0;
         end else cnt_q <= cnt_q - 4'h1;
      end else if (conv_start) begin
         busy_q <= 1'b1;
         cnt_q  <= lat;
         held_q <= code;
      end
   end
endmodule : sar_core_model
`default_nettype wire

// ### sim/test_adc_control.sv
// self-checking bench of the converter control block
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED at %0t got %h expected %h", $time, (g), (e)); end end
module test_adc_control
   import adc_ctrl_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0, nrst = 1'b0, cs_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1;
   logic        upper_byte_sel = 1'b0, data_oe_n, conv_done_n, conv_start, sar_valid;
   logic        sar_ready, shared_negative_input, acquire_external_sel, unipolar_sel;
   logic        clock_internal, core_powered, quiescent_on;
   logic [7:0]  data_in = 8'h00, data_out, pos_sel, neg_sel;
   logic [11:0] sar_result, code = 12'h000;
   logic [3:0]  lat = 4'h1;  // core answer delay
   int          failures = 0, n_checks = 0, cycles = 0;
   always #5 sys_clk = ~sys_clk;
   adc_control adc_control_i (.sys_clk(sys_clk), .nrst(nrst), .cs_n(cs_n), .wr_n(wr_n),
      .rd_n(rd_n), .upper_byte_sel(upper_byte_sel), .data_in(data_in), .data_out(data_out),
      .data_oe_n(data_oe_n), .conv_done_n(conv_done_n), .conv_start(conv_start),
      .sar_valid(sar_valid), .sar_ready(sar_ready), .sar_result(sar_result),
      .pos_sel(pos_sel), .neg_sel(neg_sel), .shared_negative_input(shared_negative_input),
      .acquire_external_sel(acquire_external_sel), .unipolar_sel(unipolar_sel),
      .clock_internal(clock_internal), .core_powered(core_powered),
      .quiescent_on(quiescent_on));
   sar_core_model sar_core_model_i (.sys_clk(sys_clk), .nrst(nrst), .conv_start(conv_start),
      .sar_ready(sar_ready), .sar_valid(sar_valid), .sar_result(sar_result), .code(code),
      .lat(lat));
   // expected bus byte; bipolar flips the offset-binary sign bit
   function automatic logic [7:0] exp_byte(input logic [11:0] c, input logic uni,
                                           input logic up);
      logic [11:0] r;
      r = uni ? c : {~c[11], c[10:0]};
      return up ? {{4{r[11] & ~uni}}, r[11:8]} : r[7:0];
   endfunction : exp_byte
   task automatic wr(input logic [7:0] b);
      @(posedge sys_clk) begin cs_n <= 1'b0; wr_n <= 1'b0; data_in <= b; end
      @(posedge sys_clk) wr_n <= 1'b1;
      @(posedge sys_clk) cs_n <= 1'b1;
   endtask : wr
   // read one byte; upper read pops the result on strobe release
   task automatic rd(input logic up, input logic [7:0] e);
      @(posedge sys_clk) begin cs_n <= 1'b0; rd_n <= 1'b0; upper_byte_sel <= up; end
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK(data_oe_n, 1'b0)
      `CHK(data_out, e)
      @(posedge sys_clk) rd_n <= 1'b1;
      @(posedge sys_clk) cs_n <= 1'b1;
   endtask : rd
   task automatic convert(input logic [7:0] cfg, input logic [11:0] c);
      int k;
      code <= c;
      wr(cfg);
      #1;
      `CHK(conv_start, 1'b1)
      @(posedge sys_clk) #1;
      `CHK({core_powered, quiescent_on}, 2'b11)
      for (k = 0; k < 60 && conv_done_n !== 1'b0; k++) @(posedge sys_clk) #1;
      `CHK(conv_done_n, 1'b0)
      rd(1'b0, exp_byte(c, cfg[3], 1'b0));
      rd(1'b1, exp_byte(c, cfg[3], 1'b1));
   endtask : convert
   task automatic report_and_stop;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   // hang guard, about ten times the cycles the run needs
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 8000) begin failures++; report_and_stop(); end
   end
   initial begin
      int a, k;
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge sys_clk) #1;
      `CHK({conv_done_n, clock_internal, pos_sel, neg_sel}, {2'b10, 8'h01, 8'h02})
      // every address, single-ended unipolar then pair bipolar
      for (a = 0; a < 8; a++) begin
         convert(8'hd8 | 8'(a), 12'(a * 585));
         `CHK({pos_sel, neg_sel, shared_negative_input}, {8'h01 << a, 9'h001})
         convert(8'he0 | 8'(a), 12'hfff - 12'(a * 585));
         `CHK({pos_sel, neg_sel, acquire_external_sel, unipolar_sel},
              {8'h01 << a, 8'h01 << (a ^ 1), 2'b10})
      end
      // power codes with a slow core; power-down keeps the clock mode
      lat <= 4'h8;
      convert(8'h98, 12'h9a5);
      `CHK({core_powered, quiescent_on, clock_internal}, 3'b111)
      convert(8'h58, 12'h35c);
      `CHK({core_powered, quiescent_on, clock_internal}, 3'b011)
      convert(8'h18, 12'hc3a);
      `CHK({core_powered, quiescent_on, clock_internal}, 3'b001)
      convert(8'hd8, 12'h7e1);
      `CHK({core_powered, quiescent_on, clock_internal}, 3'b110)
      // fill the result store until the core is held off, then drain it
      lat <= 4'h1;
      for (a = 0; a < 17; a++) begin
         code <= 12'h100 + 12'(a);
         wr(8'hd8);
         for (k = 0; k < 40 && !(sar_valid && sar_ready); k++) @(posedge sys_clk) #1;
         @(posedge sys_clk);
      end
      #1;
      `CHK({sar_ready, sar_valid}, 2'b01)
      // a write while the held conversion is busy reloads fields but starts nothing
      wr(8'hd9);
      #1;
      `CHK({conv_start, pos_sel}, {1'b0, 8'h02})
      for (a = 0; a < 17; a++) begin
         rd(1'b0, exp_byte(12'h100 + 12'(a), 1'b1, 1'b0));
         rd(1'b1, exp_byte(12'h100 + 12'(a), 1'b1, 1'b1));
      end
      repeat (2) @(posedge sys_clk) #1;
      `CHK(conv_done_n, 1'b1)
      report_and_stop();
   end
endmodule : test_adc_control
`default_nettype wire
